// [hdl/mqrp_fifo.v]
`timescale 1ns/1ps
module mqrp_fifo #(
    parameter WIDTH = 18,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    // clock and reset
    input  wire             clk_i,
    input  wire             rst_n_i,
    input  wire             ce_i,
    // fill side
    input  wire             in_valid_i,
    output wire             in_ready_o,
    input  wire [WIDTH-1:0] in_data_i,
    // drain side
    output wire             out_valid_o,
    input  wire             out_ready_i,
    output reg  [WIDTH-1:0] out_data_o,
    // flush
    input  wire             flush_i
);

reg [WIDTH-1:0] mem_r [0:DEPTH-1];
reg [AW-1:0]    wp_r;
reg [AW-1:0]    rp_r;
reg [AW:0]      cnt_r;
reg             ov_r;
wire            push;
wire            pop;
wire [AW-1:0]   rp_nxt;

assign in_ready_o  = (cnt_r != DEPTH[AW:0]);
assign push        = in_valid_i && in_ready_o;
// registered head: ov_r says out_data_o holds the oldest word
assign out_valid_o = ov_r;
assign pop         = ov_r && out_ready_i;
assign rp_nxt      = rp_r + 1'b1;

always @(posedge clk_i) begin
    if (push && ce_i && !flush_i) begin
        mem_r[wp_r] <= in_data_i;
    end
end

always @(posedge clk_i) begin
    if (!rst_n_i) begin
        wp_r       <= {AW{1'b0}};
        rp_r       <= {AW{1'b0}};
        cnt_r      <= {(AW+1){1'b0}};
        ov_r       <= 1'b0;
        out_data_o <= {WIDTH{1'b0}};
    end else if (ce_i) begin
        if (flush_i) begin
            wp_r  <= {AW{1'b0}};
            rp_r  <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
            ov_r  <= 1'b0;
        end else begin
            if (push) begin
                wp_r <= wp_r + 1'b1;
            end
            cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
            // load head register when empty or after a pop
            if (!ov_r || pop) begin
                if ((cnt_r - {{AW{1'b0}}, pop}) != {(AW+1){1'b0}}) begin
                    out_data_o <= pop ? mem_r[rp_nxt] : mem_r[rp_r];
                    ov_r       <= 1'b1;
                    rp_r       <= pop ? rp_nxt : rp_r;
                end else if (push) begin
                    out_data_o <= in_data_i;
                    ov_r       <= 1'b1;
                    rp_r       <= pop ? rp_nxt : rp_r;
                end else begin
                    ov_r <= 1'b0;
                    rp_r <= pop ? rp_nxt : rp_r;
                end
            end
        end
    end
end

endmodule // mqrp_fifo

// [hdl/mqrp_map.vh]
`ifndef MQRP_MAP_VH
`define MQRP_MAP_VH

// read select bus fields
`define MQRP_QSEL_LSB      0
`define MQRP_QSEL_MSB      3
`define MQRP_NULLQ_BIT     4
`define MQRP_SECTOR_BIT    0
`define MQRP_DEV_LSB       5
`define MQRP_DEV_MSB       7

// widths and sizes
`define MQRP_DATA_W        18
`define MQRP_NUM_Q         16
`define MQRP_FLAG_W        8
`define MQRP_FIFO_DEPTH    4

// reset values
`define MQRP_QSEL_RST      5'h10
`define MQRP_SECTOR_RST    1'h0

`endif

// [hdl/mqrp_read_port.v]
// Operation
// (R1) first edge after a queue change still outputs a word of the old queue
// (R2) second edge after queue change shows the new queue's word, no enable
// (R3) strobed flag mode: select bus bit 0 picks the flag sector
// (R4) select bus top three bits name one of eight devices; match acts
// (R5) select bus bits four to two are ignored during sector capture
// (R6) sector taken on edge with flag strobe high; old word may go out
// (R7) a read advances only on an edge with active-low read enable low; here an empty or stale output also refills without it
// (R8) queue selection is taken whatever the read enable level
// (R9) polled flag cycling and direct sector choice need no read enable
// (R10) no normal traffic until config done output has gone low
// (R11) low four bits pick one of sixteen queues; bit four is null queue
// (R12) queue address captured on edge only while select strobe high
// (R13) host never raises both strobes together; select only on changes
// (R14) host raises select strobe only after config done is low
// (R15) non-matching device ignores selection and floats its flag bus
`timescale 1ns/1ps
`include "mqrp_map.vh"
module mqrp_read_port #(
    parameter DATA_W    = `MQRP_DATA_W,
    parameter NUM_Q     = `MQRP_NUM_Q,
    parameter FLAG_W    = `MQRP_FLAG_W,
    parameter DEPTH     = `MQRP_FIFO_DEPTH,
    parameter [2:0] DEV_ID = 3'h0
) (
    // clock and reset
    input  wire              clk_i,
    input  wire              rst_n_i,
    input  wire              ce_i,
    // configuration chain
    input  wire              config_chain_in_n_i,
    input  wire              prog_done_i,
    output reg               config_done_out_n_o,
    // mode
    input  wire              polled_mode_i,
    // host read port
    input  wire [7:0]        read_select_bus_i,
    input  wire              read_select_strobe_i,
    input  wire              flag_sector_strobe_i,
    input  wire              read_en_n_i,
    output reg  [DATA_W-1:0] data_o,
    output reg               data_valid_o,
    output reg  [3:0]        cur_queue_o,
    output reg               null_queue_o,
    // memory side: queue words
    input  wire [DATA_W-1:0] mem_data_i,
    input  wire              mem_valid_i,
    output wire              mem_ready_o,
    output wire [3:0]        mem_queue_o,
    input  wire [NUM_Q-1:0]  queue_almost_empty_n_i,
    // flag bus
    output reg  [FLAG_W-1:0] almost_empty_flag_bus_o,
    output reg               almost_empty_flag_oe_o
);

// ************************************************
// helpers
// ************************************************
function dev_match;
    input [7:0] bus;
    begin
        dev_match = (bus[`MQRP_DEV_MSB:`MQRP_DEV_LSB] == DEV_ID);
    end
endfunction

function [FLAG_W-1:0] sector_flags;
    input [NUM_Q-1:0] fl;
    input             sec;
    begin
        sector_flags = sec ? fl[2*FLAG_W-1:FLAG_W] : fl[FLAG_W-1:0];
    end
endfunction

// ************************************************
// state
// ************************************************
localparam ST_IDLE = 2'h0;
localparam ST_OLD  = 2'h1;
localparam ST_NEW  = 2'h2;

reg  [1:0]        st_r;
reg  [1:0]        st_nxt;
reg  [4:0]        qsel_r;
reg               sector_r;
reg               sel_dev_r;
reg               poll_r;
wire              ready;
wire              qsel_hit;
wire              sec_hit;
wire              fifo_valid;
wire              fifo_in_valid;
wire              fifo_in_ready;
wire              stale;
wire [DATA_W-1:0] fifo_data;
wire              flush;
wire              take;

// ************************************************
// configuration done
// ************************************************
// (R10) gate on done
assign ready = ~config_done_out_n_o;

always @(posedge clk_i) begin
    if (!rst_n_i) begin
        config_done_out_n_o <= 1'b1;
    end else if (ce_i) begin
        config_done_out_n_o <= ~(prog_done_i & ~config_chain_in_n_i);
    end
end

// ************************************************
// selection capture
// ************************************************
// (R8) enable-independent select
// (R12) strobe-qualified capture
// (R14) ignore before ready
assign qsel_hit = ready && read_select_strobe_i && !flag_sector_strobe_i
                  && dev_match(read_select_bus_i);
// (R4) device match
// (R5) bits 4:2 unused
// (R13) both strobes: neither taken
assign sec_hit  = ready && flag_sector_strobe_i && !read_select_strobe_i
                  && !polled_mode_i;

always @(posedge clk_i) begin
    if (!rst_n_i) begin
        qsel_r    <= `MQRP_QSEL_RST;
        sector_r  <= `MQRP_SECTOR_RST;
        sel_dev_r <= 1'b0;
        poll_r    <= 1'b0;
    end else if (ce_i) begin
        // (R11) queue plus null bit
        if (qsel_hit) begin
            qsel_r <= read_select_bus_i[`MQRP_NULLQ_BIT:`MQRP_QSEL_LSB];
        end
        // (R6) sector capture edge
        if (sec_hit) begin
            sel_dev_r <= dev_match(read_select_bus_i);
        end
        // (R3) bit 0 picks sector
        // (R4) only matching device acts
        if (sec_hit && dev_match(read_select_bus_i)) begin
            sector_r <= read_select_bus_i[`MQRP_SECTOR_BIT];
        end
        // (R9) polled cycling, no enable
        if (polled_mode_i && ready) begin
            poll_r <= ~poll_r;
        end
    end
end

// ************************************************
// fall-through sequencing
// ************************************************
always @* begin
    st_nxt = st_r;
    case (st_r)
        ST_IDLE: begin
            if (qsel_hit) begin
                st_nxt = ST_OLD;
            end
        end
        ST_OLD: begin
            st_nxt = qsel_hit ? ST_OLD : ST_NEW;
        end
        ST_NEW: begin
            st_nxt = qsel_hit ? ST_OLD : ST_IDLE;
        end
        default: begin
            st_nxt = ST_IDLE;
        end
    endcase
end

always @(posedge clk_i) begin
    if (!rst_n_i) begin
        st_r <= ST_IDLE;
    end else if (ce_i) begin
        st_r <= st_nxt;
    end
end

// prefetch holds only the current queue; dropped on the select edge
// so the new queue's first word can reach data_o two edges later
assign flush         = qsel_hit;
assign mem_queue_o   = qsel_r[3:0];
// (R11) null queue fetches nothing
assign fifo_in_valid = mem_valid_i && !qsel_r[`MQRP_NULLQ_BIT] && ready;
// never take a word from memory that the buffer would drop
assign mem_ready_o   = fifo_in_ready && !qsel_r[`MQRP_NULLQ_BIT] && ready &&
                       ce_i && !flush;

mqrp_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (DEPTH),
    .AW    (2)
) mqrp_fifo_inst (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .ce_i        (ce_i),
    .in_valid_i  (fifo_in_valid),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (mem_data_i),
    .out_valid_o (fifo_valid),
    .out_ready_i (take),
    .out_data_o  (fifo_data),
    .flush_i     (flush)
);

// (R7) advance on enable, or to refill an empty output
// (R2) new queue shown regardless of enable
// a shown word of the old queue is replaced as soon as a new one exists
assign stale = ({null_queue_o, cur_queue_o} != qsel_r);
assign take  = fifo_valid && !flush &&
               ((!read_en_n_i && ready) || (st_r == ST_NEW) ||
                stale || !data_valid_o);

always @(posedge clk_i) begin
    if (!rst_n_i) begin
        data_o       <= {DATA_W{1'b0}};
        data_valid_o <= 1'b0;
        cur_queue_o  <= 4'h0;
        null_queue_o <= 1'b1;
    end else if (ce_i) begin
        // (R1) old queue word on first edge
        if (qsel_hit && fifo_valid) begin
            data_o       <= fifo_data;
            data_valid_o <= 1'b1;
        end else if (take) begin
            data_o       <= fifo_data;
            data_valid_o <= 1'b1;
            cur_queue_o  <= qsel_r[3:0];
            null_queue_o <= qsel_r[`MQRP_NULLQ_BIT];
        end else if (stale && qsel_r[`MQRP_NULLQ_BIT] && st_r != ST_OLD) begin
            data_valid_o <= 1'b0;
            cur_queue_o  <= qsel_r[3:0];
            null_queue_o <= 1'b1;
        end else if (!read_en_n_i && ready) begin
            data_valid_o <= 1'b0;
        end
    end
end

// ************************************************
// almost-empty flag bus
// ************************************************
always @(posedge clk_i) begin
    if (!rst_n_i) begin
        almost_empty_flag_bus_o <= {FLAG_W{1'b1}};
        almost_empty_flag_oe_o  <= 1'b0;
    end else if (ce_i) begin
        if (polled_mode_i) begin
            almost_empty_flag_bus_o <=
                sector_flags(queue_almost_empty_n_i, poll_r);
            almost_empty_flag_oe_o  <= ready;
        end else begin
            almost_empty_flag_bus_o <=
                sector_flags(queue_almost_empty_n_i, sector_r);
            // (R15) float when not ours
            almost_empty_flag_oe_o  <= ready && sel_dev_r;
        end
    end
end

endmodule // mqrp_read_port

// [testbench/mqrp_mem_model.sv]
`timescale 1ns/1ps
module mqrp_mem_model (
    // clock and stall
    input  wire        clk_i,
    input  wire        stall_i,
    // word source
    input  wire [3:0]  queue_i,
    input  wire        ready_i,
    output reg         valid_o,
    output wire [17:0] data_o
);
    // ****************
    // queue words
    // ****************
    reg [13:0] cnt_r [0:15];
    reg [17:0] last_r;
    integer    i;
    initial begin
        for (i = 0; i < 16; i = i + 1) cnt_r[i] = 14'h0;
        valid_o = 1'b0;
        last_r = 18'h0;
    end
    // a word stays offered until taken; idle data is the inverse of the last word offered
    always @(posedge clk_i) begin
        if (valid_o && ready_i) cnt_r[queue_i] <= cnt_r[queue_i] + 14'h1;
        if (valid_o) last_r <= data_o;
        valid_o <= (valid_o && !ready_i) || !stall_i;
    end
    assign data_o = valid_o ? {queue_i, cnt_r[queue_i]} : ~last_r;
endmodule // mqrp_mem_model

// [testbench/mqrp_read_port_assertions.sv]
`timescale 1ns/1ps
module mqrp_chk #(
    parameter       DATA_W = 18,
    parameter [2:0] DEV_ID = 3'h0
) (
    // watched ports
    input wire              clk_i,
    input wire              rst_n_i,
    input wire              ce_i,
    input wire              config_chain_in_n_i,
    input wire              prog_done_i,
    input wire              config_done_out_n_o,
    input wire              polled_mode_i,
    input wire [7:0]        read_select_bus_i,
    input wire              read_select_strobe_i,
    input wire              flag_sector_strobe_i,
    input wire              read_en_n_i,
    input wire [DATA_W-1:0] data_o,
    input wire              data_valid_o,
    input wire [3:0]        cur_queue_o,
    input wire [3:0]        mem_queue_o,
    input wire              almost_empty_flag_oe_o
);
    // ****************
    // checks
    // ****************
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    wire tk  = ce_i && !config_done_out_n_o;
    wire hit = read_select_bus_i[7:5] == DEV_ID;
    wire sel = read_select_strobe_i && !flag_sector_strobe_i && tk;
    wire sec = flag_sector_strobe_i && !read_select_strobe_i && tk;
    // edges since the select strobe was last high; flush settles within three
    reg  [2:0] since_r;
    always @(posedge clk_i)
        since_r <= (!rst_n_i || read_select_strobe_i) ? 3'h0 :
                   (since_r == 3'h7 ? since_r : since_r + 3'h1);
    a_ready_lag: assert property (ce_i |=> config_done_out_n_o ==
        !($past(prog_done_i) && !$past(config_chain_in_n_i)))
        else $error("ready output wrong");
    a_queue_take: assert property (sel && hit && !read_select_bus_i[4]
        |=> mem_queue_o == $past(read_select_bus_i[3:0]))
        else $error("queue not taken");
    a_queue_foreign: assert property (read_select_strobe_i && tk && !hit
        |=> $stable(mem_queue_o)) else $error("foreign queue taken");
    a_strobes_both: assert property (read_select_strobe_i
        && flag_sector_strobe_i && tk && !polled_mode_i
        |=> $stable(mem_queue_o) && $stable(almost_empty_flag_oe_o))
        else $error("double strobe acted");
    a_sector_take: assert property (sec && !polled_mode_i && hit
        |-> ##[1:2] almost_empty_flag_oe_o) else $error("flags not driven");
    a_sector_foreign: assert property (sec && !polled_mode_i && !hit
        |-> ##[1:2] !almost_empty_flag_oe_o) else $error("flags driven");
    a_polled_drive: assert property (polled_mode_i && tk
        |-> ##[1:2] almost_empty_flag_oe_o) else $error("polled bus idle");
    a_read_hold: assert property (data_valid_o && read_en_n_i
        && since_r > 3'h3 && !read_select_strobe_i
        && cur_queue_o == mem_queue_o |=> $stable(data_o))
        else $error("word moved without read");
    a_null_empty: assert property (sel && hit && read_select_bus_i[4]
        ##1 ce_i && !read_select_strobe_i ##1 ce_i && !read_select_strobe_i
        |=> !data_valid_o) else $error("null queue shows a word");
    c_queue: cover property (sel && hit);
    c_sector: cover property (sec && hit);
    c_pop: cover property (data_valid_o && !read_en_n_i);
endmodule // mqrp_chk

bind mqrp_read_port mqrp_chk #(.DATA_W(DATA_W), .DEV_ID(DEV_ID)) mqrp_chk_inst (
    .clk_i, .rst_n_i, .ce_i, .config_chain_in_n_i, .prog_done_i,
    .config_done_out_n_o, .polled_mode_i, .read_select_bus_i,
    .read_select_strobe_i, .flag_sector_strobe_i, .read_en_n_i, .data_o,
    .data_valid_o, .cur_queue_o, .mem_queue_o, .almost_empty_flag_oe_o);

// [testbench/multi_queue_read_port_select_test.sv]
`timescale 1ns/1ps
module multi_queue_read_port_select_test;
    localparam [2:0] DEV = 3'h5;
    reg         clk_i, rst_n_i, ce_i, chain_n, prog, polled, sel, fstr;
    reg         ren_n, stall;
    reg  [7:0]  bus;
    reg  [15:0] flags;
    reg  [3:0]  q;
    reg  [3:0]  exp_q[$];
    reg  [17:0] last;
    reg  [7:0]  fsave;
    wire [17:0] dout, mdat;
    wire        valid, done_n, mval, mrdy, nullq, oe;
    wire [3:0]  curq, mq;
    wire [7:0]  fbus;
    integer     bad_count, checked, i, n;
    mqrp_read_port #(.DEV_ID(DEV)) mqrp_read_port_inst (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
        .config_chain_in_n_i(chain_n), .prog_done_i(prog),
        .config_done_out_n_o(done_n), .polled_mode_i(polled),
        .read_select_bus_i(bus), .read_select_strobe_i(sel),
        .flag_sector_strobe_i(fstr), .read_en_n_i(ren_n), .data_o(dout),
        .data_valid_o(valid), .cur_queue_o(curq), .null_queue_o(nullq),
        .mem_data_i(mdat), .mem_valid_i(mval), .mem_ready_o(mrdy),
        .mem_queue_o(mq), .queue_almost_empty_n_i(flags),
        .almost_empty_flag_bus_o(fbus), .almost_empty_flag_oe_o(oe));
    mqrp_mem_model mqrp_mem_model_inst (.clk_i(clk_i), .stall_i(stall),
        .queue_i(mq), .ready_i(mrdy), .valid_o(mval), .data_o(mdat));
    // ****************
    // helpers
    // ****************
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    always @(posedge clk_i) stall <= ($urandom % 4) == 0;
    task chk(input bit ok);
        checked = checked + 1;
        if (!ok) begin
            bad_count = bad_count + 1;
            $display("[ERR] %0t value mismatch", $time);
        end
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task pick(input [7:0] b, input s, input f);
        @(posedge clk_i);
        bus <= b; sel <= s; fstr <= f;
        @(posedge clk_i);
        sel <= 1'b0; fstr <= 1'b0;
    endtask
    // takes the oldest noted queue once its word shows
    always @(negedge clk_i) if (rst_n_i) begin
        if (valid && exp_q.size() > 0 && dout[17:14] === exp_q[0]) begin
            chk(curq === exp_q[0]);
            void'(exp_q.pop_front()); n = 0;
        end else if (exp_q.size() > 0) begin
            n = n + 1;
            if (n > 10) begin
                chk(1'b0);
                void'(exp_q.pop_front());
                n = 0;
            end
        end
        // words of one queue come in order
        if (valid && dout !== last && dout[17:14] === last[17:14])
            chk(dout[13:0] === last[13:0] + 14'h1);
        if (valid) last = dout;
    end
    initial begin
        #(3000 * 20);
        bad_count = bad_count + 1;
        report_and_stop;
    end
    // ****************
    // tests
    // ****************
    initial begin
        rst_n_i = 0; ce_i = 1; chain_n = 1; prog = 0; polled = 0; sel = 0;
        fstr = 0; ren_n = 1; stall = 0; bus = 8'h0; flags = 16'ha35c;
        q = 4'h0; last = 18'h0; bad_count = 0; checked = 0; n = 0;
        void'($urandom(60));
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1; prog <= 1;
        repeat (3) @(posedge clk_i);
        chk(done_n === 1'b1);
        chain_n <= 0;
        repeat (3) @(posedge clk_i);
        chk(done_n === 1'b0);
        $display("ready test done");
        for (i = 0; i < 6; i = i + 1) begin
            q = q + 4'h1 + 4'($urandom % 15);
            ren_n <= $urandom % 2;
            exp_q.push_back(q);
            chk(done_n === 1'b0);
            pick({DEV, 1'b0, q}, 1, 0);
            ren_n <= 1;
            repeat (6) @(posedge clk_i);
            ren_n <= 0;
            repeat (2) @(posedge clk_i);
            ren_n <= 1;
        end
        repeat (8) @(posedge clk_i);
        chk(mrdy === 1'b0);
        ren_n <= 0;
        repeat (10) @(posedge clk_i);
        ren_n <= 1;
        $display("queue test done");
        pick({DEV, 1'b1, 4'h0}, 1, 0);
        repeat (4) @(posedge clk_i);
        chk(nullq === 1'b1);
        pick({~DEV, 5'h3}, 1, 0);
        @(posedge clk_i);
        chk(mq === 4'h0 && nullq === 1'b1);
        pick({DEV, 5'h3}, 1, 1);
        @(posedge clk_i);
        chk(mq === 4'h0 && nullq === 1'b1);
        for (i = 0; i < 4; i = i + 1) begin
            flags <= $urandom;
            pick({i[1] ? ~DEV : DEV, 4'($urandom), i[0]}, 0, 1);
            repeat (2) @(posedge clk_i);
            if (i < 2)
                chk(oe === 1'b1 && fbus === (i[0] ? flags[15:8] : flags[7:0]));
            else
                chk(oe === 1'b0);
        end
        polled <= 1;
        flags <= 16'h3cc3;
        repeat (3) @(posedge clk_i);
        chk(oe === 1'b1 && (fbus === flags[7:0] || fbus === flags[15:8]));
        ce_i <= 0;
        @(posedge clk_i);
        @(posedge clk_i);
        fsave = fbus;
        repeat (3) @(posedge clk_i);
        chk(fbus === fsave && oe === 1'b1);
        ce_i <= 1;
        $display("flag test done");
        report_and_stop;
    end
endmodule // multi_queue_read_port_select_test
